// [rtl/adt_pkg.sv]
package adt_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses on the word bus)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_RESULT_LOW = 8'h78;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h79;
	localparam logic [7:0] OFS_CONTROL_A = 8'h7a;
	localparam logic [7:0] OFS_CONTROL_B = 8'h7b;
	localparam logic [7:0] OFS_INPUT_SELECT = 8'h7c;
	localparam logic [7:0] OFS_PIN_DISABLE = 8'h7e;
	localparam logic [7:0] OFS_PORT_INPUT = 8'h80;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_LEFT_ADJUST = 5;
	localparam int BIT_ENABLE = 7;
	localparam int BIT_START = 6;
	localparam int BIT_AUTO_TRIG = 5;
	localparam int BIT_DONE = 4;
	localparam int BIT_CMP_MUX = 6;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_RESULT = 10'h000;
	localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;

	// trigger sources, in field order
	typedef enum logic [2:0] {
		TRG_FREE = 3'h0,
		TRG_COMPARATOR = 3'h1,
		TRG_EXT_INT0 = 3'h2,
		TRG_T0_CMPA = 3'h3,
		TRG_T0_OVF = 3'h4,
		TRG_T1_CMPB = 3'h5,
		TRG_T1_OVF = 3'h6,
		TRG_T1_CAPT = 3'h7
	} adt_trig_t;

	// bus answer phases, gray along idle->answer->idle
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ANSWER = 2'b01
	} adt_bus_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} adt_avreq_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} adt_avrsp_t;

	typedef struct packed {
		adt_bus_t bus;
		logic [31:0] rdata;
		logic [9:0] result;
		logic lock;
		logic leftAdjust;
		logic [4:0] channelSel;
		logic convEnable;
		logic convBusy;
		logic autoTrig;
		logic doneFlag;
		logic cmpMuxEnable;
		adt_trig_t trigSel;
		logic [7:0] pinDisable;
		logic trigPrev;
		logic startPulse;
		logic [7:0] pinSync1;
		logic [7:0] pinSync2;
		logic [7:0] portIn;
		logic waitReq;
	} adt_state_t;

endpackage

// [rtl/adt_result_trigger.sv]
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - low-byte read freezes both result bytes until high byte is read
// - left adjust: bits 9..2 in high byte, 1..0 in low 7..6
// - right adjust default: bits 9..8 in high 1..0, 7..0 low
// - result bytes read-only, reset zero, hold last conversion completed while unlocked
// - trigger source field acts only while auto triggering is enabled
// - auto mode starts conversion on selected flag rising edge if enabled
// - switching from low-flag source to high-flag source counts as an edge
// - selecting free running never itself creates a trigger event
// - trigger codes 0..7: free, comparator, int0, t0 cmpA/ovf, t1 cmpB/ovf/capt
// - input-disable bits switch off the matching pin input buffer
// - disabled pin reads zero in the port input register
// - left adjust bit 5 of mux register changes presentation at once
// - bit 5 of control a enables auto triggering on positive edges
// - done flag bit 4 sets when conversion completes, also when the lock drops the result
module adt_result_trigger (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire adt_pkg::adt_avreq_t avReq,
	output adt_pkg::adt_avrsp_t avRsp,
	input wire logic convDone,
	input wire logic [9:0] convData,
	input wire logic [7:0] eventFlags,
	input wire logic [7:0] pinLevels,
	output logic convStart,
	output logic convEnable,
	output logic [4:0] channelSel,
	output logic [7:0] pinBufferOff
);
	import adt_pkg::*;

	adt_state_t st_r;
	adt_state_t st_nxt;
	logic [7:0] lowByte;
	logic [7:0] highByte;
	logic [7:0] ctrlA;
	logic selFlag;
	logic newSelFlag;

	// ----------------------------------------------------------------
	// result presentation
	// ----------------------------------------------------------------
	always_comb begin
		// follows the live adjust bit, even mid-conversion
		if (st_r.leftAdjust) begin
			highByte = st_r.result[9:2];
			lowByte = {st_r.result[1:0], 6'h00};
		end else begin
			highByte = {6'h00, st_r.result[9:8]};
			lowByte = st_r.result[7:0];
		end
		ctrlA = {st_r.convEnable, st_r.convBusy, st_r.autoTrig,
			st_r.doneFlag, 4'h0};
	end

	// selected flag; index 0 holds done flag so free run follows it
	always_comb begin
		selFlag = (st_r.trigSel == TRG_FREE) ? st_r.doneFlag
			: eventFlags[st_r.trigSel];
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic wr;
		logic rd;
		logic edgeSeen;
		logic [31:0] rdVal;
		wr = 1'b0;
		rd = 1'b0;
		edgeSeen = 1'b0;
		rdVal = RDATA_UNMAPPED;
		st_nxt = st_r;
		st_nxt.startPulse = 1'b0;

		st_nxt.pinSync1 = pinLevels;
		st_nxt.pinSync2 = st_r.pinSync1;
		st_nxt.portIn = st_r.pinSync2 & ~st_r.pinDisable;

		// one wait cycle per access; read data is fetched at the taking
		// edge so that it already stands while waitrequest is low
		case (st_r.bus)
			BUS_IDLE: begin
				if (avReq.read || avReq.write) begin
					st_nxt.bus = BUS_ANSWER;
					rd = avReq.read;
				end
			end
			BUS_ANSWER: begin
				st_nxt.bus = BUS_IDLE;
				wr = avReq.write;
			end
			default: begin
				st_nxt.bus = BUS_IDLE;
			end
		endcase
		st_nxt.waitReq = (st_nxt.bus != BUS_ANSWER);

		if (rd) begin
			case (avReq.address)
				OFS_RESULT_LOW: begin
					rdVal = {24'h0, lowByte};
					st_nxt.lock = 1'b1;
				end
				OFS_RESULT_HIGH: begin
					rdVal = {24'h0, highByte};
					st_nxt.lock = 1'b0;
				end
				OFS_CONTROL_A: rdVal = {24'h0, ctrlA};
				OFS_CONTROL_B: rdVal = {24'h0, 1'b0, st_r.cmpMuxEnable,
					3'h0, st_r.trigSel};
				OFS_INPUT_SELECT: rdVal = {24'h0, 2'h0, st_r.leftAdjust,
					st_r.channelSel};
				OFS_PIN_DISABLE: rdVal = {24'h0, st_r.pinDisable};
				OFS_PORT_INPUT: rdVal = {24'h0, st_r.portIn};
				default: rdVal = RDATA_UNMAPPED;
			endcase
		end
		// read data stays until the next read is taken
		if (rd) begin
			st_nxt.rdata = rdVal;
		end

		if (wr) begin
			case (avReq.address)
				OFS_CONTROL_A: begin
					st_nxt.convEnable = avReq.writedata[BIT_ENABLE];
					st_nxt.autoTrig = avReq.writedata[BIT_AUTO_TRIG];
					if (avReq.writedata[BIT_START]
						&& avReq.writedata[BIT_ENABLE]) begin
						st_nxt.startPulse = 1'b1;
					end
					// write one clears the done flag
					if (avReq.writedata[BIT_DONE]) begin
						st_nxt.doneFlag = 1'b0;
					end
				end
				OFS_CONTROL_B: begin
					st_nxt.cmpMuxEnable = avReq.writedata[BIT_CMP_MUX];
					st_nxt.trigSel = adt_trig_t'(avReq.writedata[2:0]);
				end
				OFS_INPUT_SELECT: begin
					st_nxt.leftAdjust = avReq.writedata[BIT_LEFT_ADJUST];
					st_nxt.channelSel = avReq.writedata[4:0];
				end
				OFS_PIN_DISABLE: begin
					st_nxt.pinDisable = avReq.writedata[7:0];
				end
				default: begin
				end
			endcase
		end

		// ----------------------------------------------------------------
		// trigger edge detection
		// ----------------------------------------------------------------
		// compare the flag of the new selection with the registered one
		newSelFlag = (st_nxt.trigSel == TRG_FREE) ? st_r.doneFlag
			: eventFlags[st_nxt.trigSel];
		st_nxt.trigPrev = newSelFlag;
		edgeSeen = selFlag && !st_r.trigPrev;
		if (st_r.trigSel != st_nxt.trigSel) begin
			// a switch into free run never fires
			edgeSeen = (st_nxt.trigSel != TRG_FREE)
				&& newSelFlag && !st_r.trigPrev;
		end
		// only acts while auto mode is on
		if (st_r.autoTrig && st_r.convEnable && edgeSeen
			&& !st_r.convBusy) begin
			st_nxt.startPulse = 1'b1;
		end
		if (st_nxt.startPulse) begin
			st_nxt.convBusy = 1'b1;
		end

		// ----------------------------------------------------------------
		// completion
		// ----------------------------------------------------------------
		if (convDone && st_r.convBusy) begin
			st_nxt.convBusy = st_nxt.startPulse;
			st_nxt.doneFlag = 1'b1;
			// a low-byte read taken at this edge locks as well, so the
			// bytes handed out never mix two conversions
			if (!st_r.lock && !st_nxt.lock) begin
				st_nxt.result = convData;
			end
			// locked: the new sample is dropped
		end
		if (!st_nxt.convEnable) begin
			st_nxt.convBusy = 1'b0;
			st_nxt.startPulse = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '{bus: BUS_IDLE, rdata: RDATA_UNMAPPED,
				result: RST_RESULT, lock: 1'b0, leftAdjust: 1'b0,
				channelSel: 5'h00, convEnable: 1'b0, convBusy: 1'b0,
				autoTrig: 1'b0, doneFlag: 1'b0, cmpMuxEnable: 1'b0,
				trigSel: TRG_FREE, pinDisable: RST_BYTE, trigPrev: 1'b0,
				startPulse: 1'b0, pinSync1: RST_BYTE, pinSync2: RST_BYTE,
				portIn: RST_BYTE, waitReq: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avRsp = '{readdata: st_r.rdata, waitrequest: st_r.waitReq};
	assign convStart = st_r.startPulse;
	assign convEnable = st_r.convEnable;
	assign channelSel = st_r.channelSel;
	assign pinBufferOff = st_r.pinDisable;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_lock_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.lock |=> (st_r.result == $past(st_r.result)))
		else $error("result changed while locked");
	a_left_layout: assert property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.leftAdjust |-> (highByte == st_r.result[9:2]
		&& lowByte[5:0] == 6'h00))
		else $error("left adjust layout wrong");
	a_right_layout: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!st_r.leftAdjust |-> (highByte[7:2] == 6'h00
		&& lowByte == st_r.result[7:0]))
		else $error("right adjust layout wrong");
	a_no_auto_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(!st_r.autoTrig && !(wrHit())) |=> !st_r.startPulse)
		else $error("start without auto mode or write");
	a_done_sets: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(convDone && st_r.convBusy) |=> st_r.doneFlag)
		else $error("done flag not set");
	a_discard_lock: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(convDone && st_r.lock) |=> st_r.result == $past(st_r.result))
		else $error("locked result overwritten");
	a_port_masked: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_r.pinDisable == 8'hff) ##1 (st_r.pinDisable == 8'hff)
		|-> st_r.portIn == 8'h00)
		else $error("disabled pin reads one");
	a_free_no_fire: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_r.trigSel != TRG_FREE && st_nxt.trigSel == TRG_FREE
		&& !wrHit()) |=> !st_r.startPulse)
		else $error("switch to free run fired");
	c_auto_start: cover property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.autoTrig ##1 st_r.startPulse);
	c_locked_drop: cover property (@(posedge ref_clk) disable iff (sys_rst)
		convDone && st_r.lock);
	c_free_run: cover property (@(posedge ref_clk) disable iff (sys_rst)
		(st_r.autoTrig && st_r.trigSel == TRG_FREE) ##1 st_r.startPulse);
	c_left_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
		st_r.leftAdjust && avReq.read && !avRsp.waitrequest);

	function automatic logic wrHit();
		return avReq.write && (st_r.bus == BUS_ANSWER)
			&& (avReq.address == OFS_CONTROL_A);
	endfunction

endmodule // adt_result_trigger

// [testbench/adt_core_model.sv]
`timescale 1ns/1ps
module adt_core_model #(
	parameter int LATENCY = 5
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic convStart,
	input wire logic convEnable,
	input wire logic [9:0] sampleValue,
	output logic convDone,
	output logic [9:0] convData
);
	int count;
	logic [9:0] lastData;
	// data is valid in the done cycle only; at other times the inverse of the last
	// sample shows, so a capture at the wrong cycle passes only when the new sample is its inverse
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 0;
			convDone <= 1'b0;
			convData <= 10'h000;
			lastData <= 10'h000;
		end else begin
			convDone <= 1'b0;
			convData <= ~lastData;
			if (!convEnable) begin
				count <= 0;
			end else if (count == 1) begin
				convDone <= 1'b1;
				convData <= sampleValue;
				lastData <= sampleValue;
				count <= 0;
			end else if (count > 1) begin
				count <= count - 1;
			end else if (convStart) begin
				count <= LATENCY;
			end
		end
	end
endmodule // adt_core_model

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import adt_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	adt_avreq_t avReq = '0;
	adt_avrsp_t avRsp;
	logic convDone, convStart, convEnable;
	logic [9:0] convData, v, held;
	logic [9:0] sampleValue = 10'h000;
	logic [7:0] eventFlags = 8'h00;
	logic [7:0] pinLevels = 8'h00;
	logic [4:0] channelSel;
	logic [7:0] pinBufferOff, rd, dis;
	logic [31:0] lfsr = 32'h81f0;
	logic lft;
	int errors = 0;
	int samples_checked = 0;
	int starts = 0;
	int s0;
	logic [7:0] ofs [6] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e};

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (convStart === 1'b1) starts <= starts + 1;

	adt_result_trigger dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.avReq(avReq), .avRsp(avRsp), .convDone(convDone),
		.convData(convData), .eventFlags(eventFlags), .pinLevels(pinLevels),
		.convStart(convStart), .convEnable(convEnable),
		.channelSel(channelSel), .pinBufferOff(pinBufferOff));
	adt_core_model #(.LATENCY(5)) core (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.convStart(convStart), .convEnable(convEnable),
		.sampleValue(sampleValue), .convDone(convDone), .convData(convData));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [7:0] rb(logic [9:0] d, logic left, logic hi);
		if (left) return hi ? d[9:2] : {d[1:0], 6'h00};
		return hi ? {6'h00, d[9:8]} : d[7:0];
	endfunction
	task automatic complete_run();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic ticks(int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// request held until the edge that samples waitrequest low
	task automatic bus(logic wr, logic [7:0] a, logic [7:0] wd);
		int n;
		@(posedge ref_clk);
		avReq.read <= !wr;
		avReq.write <= wr;
		avReq.address <= a;
		avReq.writedata <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avRsp.waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			errors++;
			complete_run();
		end
		rd = avRsp.readdata[7:0];
		avReq.read <= 1'b0;
		avReq.write <= 1'b0;
	endtask
	task automatic rchk(string what, logic [7:0] a, logic [7:0] exp);
		bus(1'b0, a, 8'h00);
		check(what, exp, rd);
	endtask
	task automatic convert(logic [9:0] d);
		int n;
		sampleValue <= d;
		bus(1'b1, OFS_CONTROL_A, 8'hd0);
		n = 0;
		do begin
			bus(1'b0, OFS_CONTROL_A, 8'h00);
			n++;
		end while (rd[BIT_DONE] !== 1'b1 && n < 20);
		check("done flag", 8'h01, {7'h00, rd[BIT_DONE]});
	endtask
	task automatic start_chk(string what, int exp);
		ticks(3);
		check(what, 8'(exp), 8'(starts));
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		ticks(8);
		sys_rst <= 1'b0;
		foreach (ofs[i]) rchk("reset value", ofs[i], 8'h00);
		rchk("unmapped", 8'h70, 8'h00);
		bus(1'b1, OFS_RESULT_LOW, 8'hff);
		bus(1'b1, OFS_RESULT_HIGH, 8'hff);
		rchk("result read only", OFS_RESULT_LOW, 8'h00);
		rchk("high read only", OFS_RESULT_HIGH, 8'h00);
		bus(1'b1, OFS_CONTROL_B, 8'h7f);
		rchk("control b unused", OFS_CONTROL_B, 8'h47);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : 10'(rnd());
			lft = 1'(rnd());
			bus(1'b1, OFS_INPUT_SELECT, {2'b00, lft, 5'h00});
			convert(v);
			rchk("low byte", OFS_RESULT_LOW, rb(v, lft, 1'b0));
			rchk("high byte", OFS_RESULT_HIGH, rb(v, lft, 1'b1));
		end
		// a conversion finishing under the lock must be lost
		held = v;
		bus(1'b1, OFS_INPUT_SELECT, 8'h00);
		rchk("lock low", OFS_RESULT_LOW, rb(held, 1'b0, 1'b0));
		convert(~held);
		bus(1'b1, OFS_INPUT_SELECT, 8'h20);
		rchk("locked high", OFS_RESULT_HIGH, rb(held, 1'b1, 1'b1));
		rchk("after unlock", OFS_RESULT_LOW, rb(held, 1'b1, 1'b0));
		rchk("unlock again", OFS_RESULT_HIGH, rb(held, 1'b1, 1'b1));
		bus(1'b1, OFS_CONTROL_A, 8'ha0);
		for (int k = 1; k < 8; k++) begin
			bus(1'b1, OFS_CONTROL_B, 8'(k));
			ticks(2);
			s0 = starts;
			eventFlags[k] <= 1'b1;
			start_chk("auto start", s0 + 1);
			ticks(8);
			eventFlags <= 8'h00;
		end
		ticks(1);
		s0 = starts;
		eventFlags[2] <= 1'b1;
		bus(1'b1, OFS_CONTROL_B, 8'h02);
		start_chk("source switch", s0 + 1);
		ticks(8);
		eventFlags <= 8'h00;
		bus(1'b1, OFS_CONTROL_B, 8'h01);
		s0 = starts;
		bus(1'b1, OFS_CONTROL_B, 8'h00);
		start_chk("free run select", s0);
		bus(1'b1, OFS_CONTROL_A, 8'h90);
		bus(1'b1, OFS_CONTROL_B, 8'h03);
		s0 = starts;
		eventFlags[3] <= 1'b1;
		start_chk("auto off", s0);
		eventFlags <= 8'h00;
		// free run: start bit, then one restart on the done flag edge
		s0 = starts;
		bus(1'b1, OFS_CONTROL_B, 8'h00);
		bus(1'b1, OFS_CONTROL_A, 8'he0);
		ticks(30);
		check("free run starts", 8'(s0 + 2), 8'(starts));
		rchk("high only", OFS_RESULT_HIGH, rb(~held, 1'b1, 1'b1));
		for (int i = 0; i < 5; i++) begin
			pinLevels <= 8'(rnd());
			dis = (i == 0) ? 8'hff : 8'(rnd());
			bus(1'b1, OFS_PIN_DISABLE, dis);
			ticks(3);
			check("buffer off", dis, pinBufferOff);
			rchk("disable reg", OFS_PIN_DISABLE, dis);
			rchk("port input", OFS_PORT_INPUT, pinLevels & ~dis);
		end
		complete_run();
	end
endmodule // tb_top
